// File: hdl/port_pin_consts.svh
// Constants for the port pin interrupt I/O block
// Behaviour
// - Eight pins per port, one request per port
// - Per-pin edge mode: rise, fall, both, none
// - Matching edge sets status bit, raises request
// - Edge detection freezes while clock enable is low
// - No level-sensitive detection in this unit
// - Separate pin readback and drive registers
// - Configuration writable per port or per pin
// - Eight drive modes, reset from user value
// - Port threshold choice, per-pin input disable
// - Regulated output forbids resistive pull modes
// - Special pins pair on one reference choice
// - Every pin usable by CPU and peripherals
`ifndef PORT_PIN_CONSTS_SVH
`define PORT_PIN_CONSTS_SVH
`define PINS_PER_PORT 8
`define EDGE_NONE 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3
`define DRIVE_PULL_UP 3'h2
`define DRIVE_PULL_DOWN 3'h3
`define DRIVE_STRONG 3'h6
`define REF_HALF_VDDIO 2'h0
`endif

// File: hdl/port_pin_interrupt_io.sv
// One eight-pin port: data, configuration and pin event unit
`timescale 1ns/1ps
`include "port_pin_consts.svh"
module port_pin_interrupt_io #(
   parameter int NPINS = `PINS_PER_PORT
) (
   input wire logic clk_i, // System clock
   input wire logic rst_i, // Synchronous reset, active high
   input wire logic ce_i, // Clock enable, freezes all state
   input wire logic [NPINS-1:0] pin_in_i, // Pad input levels
   input wire logic [NPINS-1:0] periph_out_i, // Peripheral drive values
   input wire logic [NPINS-1:0] periph_sel_i, // Pin owned by peripheral
   input wire logic [NPINS-1:0] reset_drive_i, // User port reset state
   input wire logic drive_wr_i, // Write whole drive register
   input wire logic [NPINS-1:0] drive_wdata_i, // Drive data, port write
   input wire logic pin_wr_i, // Single-pin configuration write
   input wire logic port_wr_i, // Whole-port configuration write
   input wire logic [2:0] pin_idx_i, // Pin index for single writes
   input wire logic pin_drive_bit_i, // Drive value, pin write
   input wire logic [2:0] cfg_mode_i, // Drive mode to write
   input wire logic [1:0] cfg_edge_i, // Edge mode to write
   input wire logic cfg_ibuf_off_i, // Input buffer disable to write
   input wire logic cfg_reg_out_i, // Regulated output to write
   input wire logic lvttl_i, // Port threshold select
   input wire logic [1:0] ref_wr_i, // Pair reference write strobes
   input wire logic [1:0] ref_sel_i, // Pair reference value
   input wire logic status_rd_i, // Status register read strobe
   output logic [NPINS-1:0] pin_state_readback_o, // Sampled pins
   output logic [NPINS-1:0] pin_drive_value_o, // Output drive
   output logic [NPINS-1:0] pin_oe_o, // Output enable per pin
   output logic [3*NPINS-1:0] drive_mode_o, // Drive modes to pads
   output logic [NPINS-1:0] ibuf_en_o, // Input buffer enables
   output logic [NPINS-1:0] reg_out_o, // Regulated output selects
   output logic lvttl_o, // Port threshold to pads
   output logic [3:0] ref_sel_o, // Reference per special pair
   output logic [NPINS-1:0] irq_status_o, // Port interrupt status
   output logic [NPINS-1:0] irq_status_rdata_o, // Value seen by read
   output logic irq_req_o // Port request to controller
);
   logic [NPINS-1:0] sync1;
   logic [NPINS-1:0] sync2;
   logic [NPINS-1:0] prev;
   logic [NPINS-1:0] hit;
   logic [NPINS-1:0] drive_reg;
   logic [NPINS-1:0] ibuf_off;
   logic load_user;
   port_pin_pkg::edge_mode_t edge_mode [NPINS];
   port_pin_pkg::drive_mode_t mode [NPINS];

   // Two-stage synchroniser then edge history, frozen while ce_i is low
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sync1 <= '0;
         sync2 <= '0;
         prev <= '0;
      end
      else if (ce_i)
      begin
         sync1 <= pin_in_i;
         sync2 <= sync1;
         prev <= sync2;
      end
   end

   // Per-pin configuration and edge match
   generate
      for (genvar i = 0; i < NPINS; i++)
      begin : g_pin
         logic sel;
         logic pull;
         assign sel = port_wr_i | (pin_wr_i & (pin_idx_i == 3'(i)));
         assign pull = cfg_mode_i == `DRIVE_PULL_UP ||
                       cfg_mode_i == `DRIVE_PULL_DOWN;
         // Edge mode only; there is no level detection
         assign hit[i] =
            ((edge_mode[i] == `EDGE_RISE || edge_mode[i] == `EDGE_BOTH)
             & sync2[i] & ~prev[i]) |
            ((edge_mode[i] == `EDGE_FALL || edge_mode[i] == `EDGE_BOTH)
             & ~sync2[i] & prev[i]);
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               edge_mode[i] <= `EDGE_NONE;
               mode[i] <= `DRIVE_STRONG;
               ibuf_off[i] <= 1'b0;
               reg_out_o[i] <= 1'b0;
            end
            else if (ce_i && sel)
            begin
               edge_mode[i] <= cfg_edge_i;
               ibuf_off[i] <= cfg_ibuf_off_i;
               // Regulated output refuses resistive pull modes
               if (!(cfg_reg_out_i && pull))
               begin
                  mode[i] <= cfg_mode_i;
                  reg_out_o[i] <= cfg_reg_out_i;
               end
            end
         end
      end
   endgenerate

   // Drive register: port write or single-pin write, reset from user
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         drive_reg <= '0;
      else if (ce_i && load_user)
         drive_reg <= reset_drive_i;
      else if (ce_i && drive_wr_i)
         drive_reg <= drive_wdata_i;
      else if (ce_i && pin_wr_i)
         drive_reg[pin_idx_i] <= pin_drive_bit_i;
   end

   // User reset state is loaded the cycle after reset releases
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         load_user <= 1'b1;
      else if (ce_i)
         load_user <= 1'b0;
   end

   // Pad outputs, peripherals may own any pin
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pin_drive_value_o <= '0;
         pin_oe_o <= '0;
         pin_state_readback_o <= '0;
         ibuf_en_o <= '0;
         lvttl_o <= 1'b0;
         drive_mode_o <= '0;
      end
      else if (ce_i)
      begin
         pin_drive_value_o <= load_user ? reset_drive_i :
            (periph_sel_i & periph_out_i) | (~periph_sel_i & drive_reg);
         pin_oe_o <= '1;
         pin_state_readback_o <= sync2 & ~ibuf_off;
         ibuf_en_o <= ~ibuf_off;
         lvttl_o <= lvttl_i;
         for (int k = 0; k < NPINS; k++)
            drive_mode_o[3*k +: 3] <= mode[k];
      end
   end

   // Special-pin pair references, one per pair
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ref_sel_o <= {`REF_HALF_VDDIO, `REF_HALF_VDDIO};
      else if (ce_i)
      begin
         if (ref_wr_i[0])
            ref_sel_o[1:0] <= ref_sel_i;
         if (ref_wr_i[1])
            ref_sel_o[3:2] <= ref_sel_i;
      end
   end

   // Status: set wins over read-clear; request is OR of status
   logic [NPINS-1:0] next_status;
   assign next_status = (status_rd_i ? '0 : irq_status_o) | hit;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_status_o <= '0;
         irq_status_rdata_o <= '0;
         irq_req_o <= 1'b0;
      end
      else if (ce_i)
      begin
         irq_status_o <= next_status;
         irq_req_o <= |next_status;
         if (status_rd_i)
            irq_status_rdata_o <= irq_status_o;
      end
   end

   // Checks
   sequence rise_seen(int p);
      !prev[p] ##1 prev[p];
   endsequence
   // Mode that was live on the edge where the rise was compared
   sequence rise_wanted(int p);
      $past(edge_mode[p]) == `EDGE_RISE || $past(edge_mode[p]) == `EDGE_BOTH;
   endsequence

   sync_chain_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i |=> sync2 == $past(sync1))
      else $error("synchroniser stage skipped");
   status_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && |hit |=> (irq_status_o & $past(hit)) == $past(hit))
      else $error("edge did not set status");
   status_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !status_rd_i |=> (irq_status_o & $past(irq_status_o))
         == $past(irq_status_o))
      else $error("status dropped without read");
   req_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_req_o == |irq_status_o)
      else $error("request disagrees with status");
   read_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && status_rd_i && !(|hit) |=> irq_status_o == '0)
      else $error("read did not clear status");
   none_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
      edge_mode[0] == `EDGE_NONE |-> !hit[0])
      else $error("disabled pin raised event");
   rise_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
      edge_mode[0] == `EDGE_RISE && hit[0] |-> sync2[0] && !prev[0])
      else $error("rise mode fired on non-rise");
   no_pull_reg_a: assert property (@(posedge clk_i) disable iff (rst_i)
      reg_out_o[0] |-> mode[0] != `DRIVE_PULL_UP &&
         mode[0] != `DRIVE_PULL_DOWN)
      else $error("pull mode with regulated output");
   readback_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i |=> pin_state_readback_o == ($past(sync2) & ~$past(ibuf_off)))
      else $error("readback does not follow synchronised pins");
   rise_cover_a: assert property (@(posedge clk_i) disable iff (rst_i)
      rise_seen(0) ##0 rise_wanted(0) |-> irq_status_o[0])
      else $error("wanted rise did not set status");
endmodule

// File: hdl/port_pin_pkg.sv
// Types for the port pin interrupt I/O block
package port_pin_pkg;
   typedef logic [2:0] drive_mode_t;
   typedef logic [1:0] edge_mode_t;
   typedef logic [1:0] ref_sel_t;
endpackage

// File: verification/pin_source.sv
// Model of the external signals seen on the port pins
`timescale 1ns/1ps
module pin_source (
   input wire logic clk_i, // System clock
   output logic [7:0] pin_o // Levels at the pads
);
   // Pads start low, as if held by a weak pull-down
   initial pin_o = 8'h00;
   // Move pad levels just after an edge; they hold until moved again
   task automatic set(input logic [7:0] v);
      @(posedge clk_i);
      pin_o <= v;
   endtask
endmodule

// File: verification/testbench.sv
// Self-checking bench for the port pin interrupt I/O block
`timescale 1ns/1ps
`include "port_pin_consts.svh"
module testbench;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic dwr = 1'b0, pwr = 1'b0, prt = 1'b0, pdb = 1'b0;
   logic ibo = 1'b0, rgo = 1'b0, lvt = 1'b0, rd = 1'b0;
   logic ce = 1'b1;
   logic [7:0] psel = 8'h00, pout = 8'h00;
   logic [7:0] dwd = 8'h00;
   logic [7:0] pins;
   logic [7:0] e;
   logic [2:0] idx = 3'h0, mode = 3'h6;
   logic [1:0] edg = 2'h0, rwr = 2'h0, rsel = 2'h0;
   logic [7:0] ps, pd, oe, ib, ro, st, sr;
   logic [23:0] dm;
   logic lo, req;
   logic [3:0] rf;
   int errors = 0;
   int checks_done = 0;
   // Free-running 100 MHz clock
   always #5 clk_i = ~clk_i;
   pin_source i_pin_source (.clk_i(clk_i), .pin_o(pins));
   port_pin_interrupt_io i_port_pin_interrupt_io (.clk_i(clk_i),
      .rst_i(rst_i), .ce_i(ce), .pin_in_i(pins), .periph_out_i(pout),
      .periph_sel_i(psel), .reset_drive_i(8'h5a), .drive_wr_i(dwr),
      .drive_wdata_i(dwd), .pin_wr_i(pwr), .port_wr_i(prt),
      .pin_idx_i(idx), .pin_drive_bit_i(pdb), .cfg_mode_i(mode),
      .cfg_edge_i(edg), .cfg_ibuf_off_i(ibo), .cfg_reg_out_i(rgo),
      .lvttl_i(lvt), .ref_wr_i(rwr), .ref_sel_i(rsel),
      .status_rd_i(rd), .pin_state_readback_o(ps),
      .pin_drive_value_o(pd), .pin_oe_o(oe), .drive_mode_o(dm),
      .ibuf_en_o(ib), .reg_out_o(ro), .lvttl_o(lo), .ref_sel_o(rf),
      .irq_status_o(st), .irq_status_rdata_o(sr), .irq_req_o(req));
   task automatic summarize();
      $display("errors=%0d checks_done=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Wait edges, then step past them so outputs have settled
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // One configuration write, whole port or one pin
   task automatic cfg(input logic p, input logic [2:0] i, m,
                      input logic [1:0] g, input logic b, r, d);
      @(posedge clk_i);
      prt <= p;
      pwr <= ~p;
      idx <= i;
      mode <= m;
      edg <= g;
      ibo <= b;
      rgo <= r;
      pdb <= d;
      @(posedge clk_i);
      prt <= 1'b0;
      pwr <= 1'b0;
      cyc(3);
   endtask
   // Status read: captured value comes back, bits and request drop
   task automatic rdst(input logic [7:0] x);
      @(posedge clk_i);
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      cyc(2);
      chk(sr, x);
      chk({st, req}, 9'h000);
   endtask
   // Hang guard, far beyond the 180 or so cycles the tests need
   initial
   begin
      #50000;
      errors++;
      summarize();
   end
   initial
   begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      cyc(3);
      chk(pd, 8'h5a);
      chk(dm, {8{`DRIVE_STRONG}});
      chk(oe, 8'hff);
      // Every edge mode against one rise and one fall on pin 0
      for (int m = 0; m < 4; m++)
      begin
         cfg(1'b1, 3'h0, `DRIVE_STRONG, m[1:0], 1'b0, 1'b0, 1'b0);
         i_pin_source.set(8'h01);
         cyc(5);
         e = (m[1:0] == `EDGE_RISE || m[1:0] == `EDGE_BOTH) ? 8'h01 : 8'h00;
         chk({st, req}, {e, e[0]});
         chk(ps, 8'h01);
         rdst(e);
         i_pin_source.set(8'h00);
         cyc(5);
         e = (m[1:0] == `EDGE_FALL || m[1:0] == `EDGE_BOTH) ? 8'h01 : 8'h00;
         chk({st, req}, {e, e[0]});
         rdst(e);
      end
      // Clock enable low freezes the pin event unit, then it resumes
      @(posedge clk_i);
      ce <= 1'b0;
      i_pin_source.set(8'h02);
      cyc(5);
      chk({st, req, ps}, 17'h0_0000);
      @(posedge clk_i);
      ce <= 1'b1;
      cyc(5);
      chk({st, req}, 9'h005);
      chk(ps, 8'h02);
      rdst(8'h02);
      i_pin_source.set(8'h00);
      cyc(5);
      rdst(8'h02);
      // Whole drive write, then a single-pin write over it
      @(posedge clk_i);
      dwr <= 1'b1;
      dwd <= 8'ha5;
      @(posedge clk_i);
      dwr <= 1'b0;
      cyc(3);
      chk(pd, 8'ha5);
      cfg(1'b0, 3'h5, `DRIVE_PULL_UP, `EDGE_NONE, 1'b0, 1'b0, 1'b0);
      chk(pd, 8'h85);
      chk(dm[17:15], `DRIVE_PULL_UP);
      chk(dm[14:12], `DRIVE_STRONG);
      // Peripheral owns the low nibble, register drives the rest
      @(posedge clk_i);
      psel <= 8'h0f;
      pout <= 8'h03;
      cyc(3);
      chk(pd, 8'h83);
      @(posedge clk_i);
      psel <= 8'h00;
      // Regulated output refuses resistive pull modes
      cfg(1'b1, 3'h0, `DRIVE_STRONG, `EDGE_NONE, 1'b0, 1'b1, 1'b0);
      chk(ro, 8'hff);
      cfg(1'b1, 3'h0, `DRIVE_PULL_DOWN, `EDGE_BOTH, 1'b0, 1'b1, 1'b0);
      chk(dm, {8{`DRIVE_STRONG}});
      // Input buffers off hide the pads from readback
      cfg(1'b1, 3'h0, `DRIVE_STRONG, `EDGE_NONE, 1'b1, 1'b0, 1'b0);
      i_pin_source.set(8'hff);
      cyc(4);
      chk({ib, ps}, 16'h0000);
      // Port threshold and pair 1 reference choice
      @(posedge clk_i);
      lvt <= 1'b1;
      rwr <= 2'b10;
      rsel <= 2'h3;
      @(posedge clk_i);
      rwr <= 2'b00;
      cyc(3);
      chk(lo, 1'b1);
      chk(rf, 4'hc);
      summarize();
   end
endmodule
